// File: rtl/vbp_pkg.sv
package vbp_pkg;

  // ----------------------------------------------------------------
  // Access encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] ENC_OP0      = 2'h3;
  localparam logic [2:0] ENC_OP1      = 3'h0;
  localparam logic [3:0] ENC_CRN      = 4'hc;
  localparam logic [3:0] ENC_CRM_AP1  = 4'h9;
  localparam logic [3:0] ENC_CRM_BP0  = 4'h8;
  localparam logic [3:0] ENC_CRM_BP1  = 4'hc;
  localparam logic [2:0] ENC_OP2_BP   = 3'h3;
  localparam logic       ENC_OP2_AP1  = 1'h0;

  // ----------------------------------------------------------------
  // Register layout and reset values
  // ----------------------------------------------------------------
  localparam int          NUM_AP      = 4;
  localparam int          AP_IDX_W    = 2;
  localparam int          BP_W        = 3;
  localparam logic [31:0] AP_RESET    = 32'h0;
  localparam logic [2:0]  BP_MAX      = 3'h7;
  localparam logic [2:0]  BP_ONE      = 3'h1;
  localparam logic [2:0]  BP_ZERO     = 3'h0;
  localparam logic [2:0]  PRI_FULL    = 3'h7;
  localparam logic [2:0]  PRI_SPAN    = 3'h6;
  localparam logic [7:0]  PRIO_ALL    = 8'hff;
  localparam logic [7:0]  PRIO_NONE   = 8'h00;

  typedef enum {
    VBP_SEL_NONE,
    VBP_SEL_AP1,
    VBP_SEL_BP0,
    VBP_SEL_BP1
  } vbp_sel_t;

  typedef enum {
    VBP_RSP_OK,
    VBP_RSP_PHYS,
    VBP_RSP_TRAP_EL1,
    VBP_RSP_TRAP_EL2,
    VBP_RSP_UNMAPPED
  } vbp_rsp_t;

  // Field reports implemented bits minus one; minimum is seven minus bits
  function automatic logic [2:0] vbp_min_bp0(input logic [2:0] pri_field);
    if (pri_field == PRI_FULL) begin
      return BP_ZERO;
    end
    return 3'(PRI_SPAN - pri_field);
  endfunction

  // Preemption mask: priority bits at or above lsb are group bits
  function automatic logic [7:0] vbp_group_mask(input logic [3:0] lsb);
    if (lsb > 4'h7) begin
      return PRIO_NONE;
    end
    return 8'(PRIO_ALL << lsb);
  endfunction

endpackage

// File: rtl/vbp_dec_if.sv
`timescale 1ns/1ps
interface vbp_dec_if;
  logic [1:0]            op0;
  logic [2:0]            op1;
  logic [3:0]            crn;
  logic [3:0]            crm;
  logic [2:0]            op2;
  logic                  ns_el1;
  logic                  irq_route;
  logic                  fiq_route;
  logic                  sre;
  logic                  tall0;
  logic                  tall1;
  vbp_pkg::vbp_sel_t     sel;
  logic [1:0]            ap_idx;
  logic                  virt;
  logic                  trap_el1;
  logic                  trap_el2;

  modport core (
    output op0, op1, crn, crm, op2, ns_el1, irq_route, fiq_route,
    output sre, tall0, tall1,
    input  sel, ap_idx, virt, trap_el1, trap_el2
  );
  modport dec (
    input  op0, op1, crn, crm, op2, ns_el1, irq_route, fiq_route,
    input  sre, tall0, tall1,
    output sel, ap_idx, virt, trap_el1, trap_el2
  );
endinterface

// File: rtl/vbp_decode.sv
`timescale 1ns/1ps
module vbp_decode (
  vbp_dec_if.dec d
);

  logic common;
  logic grp0;

  // ----------------------------------------------------------------
  // Encoding match
  // ----------------------------------------------------------------
  always_comb begin
    common   = (d.op0 == vbp_pkg::ENC_OP0) && (d.op1 == vbp_pkg::ENC_OP1) &&
               (d.crn == vbp_pkg::ENC_CRN);
    d.sel    = vbp_pkg::VBP_SEL_NONE;
    d.ap_idx = d.op2[1:0];
    if (common && d.crm == vbp_pkg::ENC_CRM_AP1 &&
        d.op2[2] == vbp_pkg::ENC_OP2_AP1) begin
      d.sel = vbp_pkg::VBP_SEL_AP1;
    end else if (common && d.crm == vbp_pkg::ENC_CRM_BP0 &&
                 d.op2 == vbp_pkg::ENC_OP2_BP) begin
      d.sel = vbp_pkg::VBP_SEL_BP0;
    end else if (common && d.crm == vbp_pkg::ENC_CRM_BP1 &&
                 d.op2 == vbp_pkg::ENC_OP2_BP) begin
      d.sel = vbp_pkg::VBP_SEL_BP1;
    end
  end

  // ----------------------------------------------------------------
  // Routing and traps
  // ----------------------------------------------------------------
  always_comb begin
    grp0 = (d.sel == vbp_pkg::VBP_SEL_BP0);
    // Virtual copies exist only for non-secure EL1
    d.virt = d.ns_el1 && (d.sel != vbp_pkg::VBP_SEL_NONE) &&
             (grp0 ? d.fiq_route : d.irq_route);
    d.trap_el1 = d.virt && !d.sre;
    // EL1 trap takes priority over the hypervisor trap
    d.trap_el2 = d.virt && d.sre &&
                 (grp0 ? d.tall0 : d.tall1);
  end

endmodule

// File: rtl/vbp_regs.sv
`timescale 1ns/1ps
module vbp_regs (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // System-register access from the core
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic [1:0]  req_op0_i,
  input  wire logic [2:0]  req_op1_i,
  input  wire logic [3:0]  req_crn_i,
  input  wire logic [3:0]  req_crm_i,
  input  wire logic [2:0]  req_op2_i,
  input  wire logic        req_ns_el1_i,
  input  wire logic [31:0] req_wdata_i,
  // Control bits from the rest of the interface
  input  wire logic        virtual_irq_routing_bit_i,
  input  wire logic        virtual_fiq_routing_bit_i,
  input  wire logic        el1_sysreg_enable_bit_i,
  input  wire logic        trap_all_group0_bit_i,
  input  wire logic        trap_all_group1_bit_i,
  input  wire logic        common_binary_point_bit_i,
  input  wire logic [2:0]  priority_bit_count_i,
  // Access answer
  output logic             rsp_valid_o,
  output logic [31:0]      rsp_rdata_o,
  output logic             rsp_phys_o,
  output logic             rsp_trap_el1_o,
  output logic             rsp_trap_el2_o,
  output logic             rsp_unmapped_o,
  // Priority split for the prioritisation logic
  output logic [2:0]       group0_binary_point_o,
  output logic [2:0]       group1_binary_point_o,
  output logic [7:0]       group0_preempt_mask_o,
  output logic [7:0]       group1_preempt_mask_o,
  output logic             group1_any_active_o
);

  typedef struct packed {
    logic [vbp_pkg::NUM_AP-1:0][31:0] ap;
    logic [2:0]                       bp0;
    logic [2:0]                       bp1;
    logic                             rsp_valid;
    logic [31:0]                      rdata;
    logic                             phys;
    logic                             trap_el1;
    logic                             trap_el2;
    logic                             unmapped;
    logic [7:0]                       mask0;
    logic [7:0]                       mask1;
  } vbp_state_t;

  vbp_state_t state;
  vbp_state_t next_state;

  vbp_dec_if dec_bus ();

  logic [2:0] min_bp0;
  logic [2:0] min_bp1;
  logic [2:0] wr_bp;
  logic [2:0] bp1_alias;
  logic [2:0] bp1_eff;
  logic       any_active;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign dec_bus.op0       = req_op0_i;
  assign dec_bus.op1       = req_op1_i;
  assign dec_bus.crn       = req_crn_i;
  assign dec_bus.crm       = req_crm_i;
  assign dec_bus.op2       = req_op2_i;
  assign dec_bus.ns_el1    = req_ns_el1_i;
  assign dec_bus.irq_route = virtual_irq_routing_bit_i;
  assign dec_bus.fiq_route = virtual_fiq_routing_bit_i;
  assign dec_bus.sre       = el1_sysreg_enable_bit_i;
  assign dec_bus.tall0     = trap_all_group0_bit_i;
  assign dec_bus.tall1     = trap_all_group1_bit_i;

  vbp_decode u_decode (
    .d (dec_bus)
  );

  // ----------------------------------------------------------------
  // Derived values
  // ----------------------------------------------------------------
  always_comb begin
    min_bp0   = vbp_pkg::vbp_min_bp0(priority_bit_count_i);
    min_bp1   = 3'(min_bp0 + vbp_pkg::BP_ONE);
    wr_bp     = req_wdata_i[vbp_pkg::BP_W-1:0];
    // Saturate so that a group-0 value of seven still reads as seven
    bp1_alias = (state.bp0 == vbp_pkg::BP_MAX) ? vbp_pkg::BP_MAX :
                3'(state.bp0 + vbp_pkg::BP_ONE);
    bp1_eff   = common_binary_point_bit_i ? bp1_alias : state.bp1;
    any_active = |state.ap;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_state.rsp_valid = req_valid_i;
    next_state.phys      = 1'b0;
    next_state.trap_el1  = 1'b0;
    next_state.trap_el2  = 1'b0;
    next_state.unmapped  = 1'b0;
    // Zero-extended field keeps bits 31..3 reading as zero
    next_state.rdata     = vbp_pkg::AP_RESET;
    next_state.mask0     = vbp_pkg::vbp_group_mask(
                             4'(state.bp0) + 4'h1);
    next_state.mask1     = (bp1_eff == vbp_pkg::BP_ZERO) ?
                           vbp_pkg::PRIO_NONE :
                           vbp_pkg::vbp_group_mask(4'(bp1_eff));

    if (req_valid_i) begin
      if (dec_bus.sel == vbp_pkg::VBP_SEL_NONE) begin
        next_state.unmapped = 1'b1;
      end else if (!dec_bus.virt) begin
        next_state.phys = 1'b1;
      end else if (dec_bus.trap_el1) begin
        next_state.trap_el1 = 1'b1;
      end else if (dec_bus.trap_el2) begin
        next_state.trap_el2 = 1'b1;
      end else if (dec_bus.sel == vbp_pkg::VBP_SEL_AP1) begin
        if (req_write_i) begin
          next_state.ap[dec_bus.ap_idx] = req_wdata_i;
        end else begin
          next_state.rdata = state.ap[dec_bus.ap_idx];
        end
      end else if (dec_bus.sel == vbp_pkg::VBP_SEL_BP0) begin
        if (req_write_i) begin
          next_state.bp0 = (wr_bp < min_bp0) ? min_bp0 : wr_bp;
        end else begin
          next_state.rdata = {29'h0, state.bp0};
        end
      end else begin
        if (req_write_i && !common_binary_point_bit_i) begin
          // Zero is below the reset value, so it also lands here
          next_state.bp1 = (wr_bp < min_bp1) ? min_bp1 : wr_bp;
        end else if (!req_write_i) begin
          next_state.rdata = {29'h0, bp1_eff};
        end
      end
    end

    if (!reset_n_i) begin
      // Reset values follow the priority width seen at reset
      next_state.ap        = '0;
      next_state.bp0       = min_bp0;
      next_state.bp1       = min_bp1;
      next_state.rsp_valid = 1'b0;
      next_state.rdata     = vbp_pkg::AP_RESET;
      next_state.phys      = 1'b0;
      next_state.trap_el1  = 1'b0;
      next_state.trap_el2  = 1'b0;
      next_state.unmapped  = 1'b0;
      next_state.mask0     = vbp_pkg::PRIO_NONE;
      next_state.mask1     = vbp_pkg::PRIO_NONE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_valid_o           = state.rsp_valid;
  assign rsp_rdata_o           = state.rdata;
  assign rsp_phys_o            = state.phys;
  assign rsp_trap_el1_o        = state.trap_el1;
  assign rsp_trap_el2_o        = state.trap_el2;
  assign rsp_unmapped_o        = state.unmapped;
  assign group0_binary_point_o = state.bp0;
  assign group1_binary_point_o = state.bp1;
  assign group0_preempt_mask_o = state.mask0;
  assign group1_preempt_mask_o = state.mask1;
  assign group1_any_active_o   = any_active;

endmodule

// File: dv/vbp_regs_asserts.sv
`timescale 1ns/1ps
module vbp_regs_asserts (
  // Clock, reset and request
  input wire logic        core_clk_i, reset_n_i, req_valid_i, req_write_i,
  input wire logic [1:0]  req_op0_i,
  input wire logic [2:0]  req_op1_i, req_op2_i, priority_bit_count_i,
  input wire logic [3:0]  req_crn_i, req_crm_i,
  input wire logic [31:0] req_wdata_i, rsp_rdata_o,
  // Control bits
  input wire logic        req_ns_el1_i, virtual_irq_routing_bit_i,
  input wire logic        virtual_fiq_routing_bit_i, el1_sysreg_enable_bit_i,
  input wire logic        trap_all_group0_bit_i, trap_all_group1_bit_i,
  input wire logic        common_binary_point_bit_i,
  // Answer and state
  input wire logic        rsp_valid_o, rsp_phys_o, rsp_trap_el1_o,
  input wire logic        rsp_trap_el2_o, group1_any_active_o,
  input wire logic [2:0]  group0_binary_point_o, group1_binary_point_o,
  input wire logic [7:0]  group0_preempt_mask_o
);
  logic [2:0] min0, exp0, sat1;
  logic [7:0] mask0;
  logic       enc, hit0, hit1, sre;
  assign min0 = (priority_bit_count_i == 3'h7) ? 3'h0
                                               : 3'h6 - priority_bit_count_i;
  assign exp0 = (req_wdata_i[2:0] < min0) ? min0 : req_wdata_i[2:0];
  assign sat1 = (group0_binary_point_o == 3'h7) ? 3'h7
                                                : group0_binary_point_o + 3'h1;
  assign mask0 = (group0_binary_point_o == 3'h7) ? 8'h00
               : 8'(8'hff << ({1'b0, group0_binary_point_o} + 4'h1));
  // Binary point encodings without the privilege and routing qualifiers
  assign enc = req_valid_i && req_op0_i == 2'h3 &&
               req_op1_i == 3'h0 && req_crn_i == 4'hc && req_op2_i == 3'h3;
  assign hit0 = enc && req_ns_el1_i && req_crm_i == 4'h8 &&
                virtual_fiq_routing_bit_i;
  assign hit1 = enc && req_ns_el1_i && req_crm_i == 4'hc &&
                virtual_irq_routing_bit_i;
  assign sre = el1_sysreg_enable_bit_i;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_rsp_lat;
    req_valid_i |=> rsp_valid_o &&
      $onehot0({rsp_phys_o, rsp_trap_el1_o, rsp_trap_el2_o});
  endproperty
  a_rsp_lat: assert property (p_rsp_lat) else $error("no answer");
  property p_no_rsp;
    !req_valid_i |=> !rsp_valid_o;
  endproperty
  a_no_rsp: assert property (p_no_rsp) else $error("stray answer");
  property p_phys;
    enc && !req_ns_el1_i && (req_crm_i == 4'h8 || req_crm_i == 4'hc)
      |=> rsp_phys_o;
  endproperty
  a_phys: assert property (p_phys) else $error("not handed off");
  property p_trap1;
    (hit0 || hit1) && !sre |=> rsp_trap_el1_o;
  endproperty
  a_trap1: assert property (p_trap1) else $error("no el1 trap");
  property p_trap2b;
    hit1 && sre && trap_all_group1_bit_i |=> rsp_trap_el2_o;
  endproperty
  a_trap2b: assert property (p_trap2b) else $error("no el2 trap");
  property p_trap2;
    hit0 && sre && trap_all_group0_bit_i |=> rsp_trap_el2_o ##1 !rsp_valid_o
      or rsp_trap_el2_o ##1 rsp_valid_o;
  endproperty
  a_trap2: assert property (p_trap2) else $error("no el2 trap");
  property p_clamp0;
    hit0 && sre && !trap_all_group0_bit_i && req_write_i
      |=> group0_binary_point_o == $past(exp0);
  endproperty
  a_clamp0: assert property (p_clamp0) else $error("bad clamp");
  property p_alias;
    hit1 && sre && !trap_all_group1_bit_i && !req_write_i &&
      common_binary_point_bit_i |=> rsp_rdata_o == {29'h0, $past(sat1)};
  endproperty
  a_alias: assert property (p_alias) else $error("bad alias");
  property p_rsvd;
    (hit0 || hit1) && !req_write_i |=> rsp_rdata_o[31:3] == 29'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper bits set");
  property p_mask0;
    reset_n_i ##1 reset_n_i |=> group0_preempt_mask_o == $past(mask0);
  endproperty
  a_mask0: assert property (p_mask0) else $error("bad mask");
  property p_reset;
    $rose(reset_n_i) |-> group0_binary_point_o == min0 &&
      group1_binary_point_o == min0 + 3'h1 && !group1_any_active_o;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset");
endmodule

bind vbp_regs vbp_regs_asserts u_vbp_regs_asserts (.*);

// File: dv/vbp_core_model.sv
`timescale 1ns/1ps
module vbp_core_model (
  // Clock
  input  wire logic        core_clk_i,
  // Request towards the registers
  output logic             req_valid_o,
  output logic             req_write_o,
  output logic [1:0]       req_op0_o,
  output logic [2:0]       req_op1_o,
  output logic [3:0]       req_crn_o,
  output logic [3:0]       req_crm_o,
  output logic [2:0]       req_op2_o,
  output logic [31:0]      req_wdata_o
);
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_op0_o   = vbp_pkg::ENC_OP0;
    req_op1_o   = vbp_pkg::ENC_OP1;
    req_crn_o   = vbp_pkg::ENC_CRN;
    req_crm_o   = 4'h0;
    req_op2_o   = 3'h0;
    req_wdata_o = 32'h0;
  end
  // CRm, op2 and write data are scrambled once taken, so stale values are never trusted
  task automatic access(input logic w, input logic [3:0] crm,
                        input logic [2:0] op2, input logic [31:0] wd);
    @(posedge core_clk_i);
    req_valid_o <= 1'b1;
    req_write_o <= w;
    req_crm_o   <= crm;
    req_op2_o   <= op2;
    req_wdata_o <= wd;
    @(posedge core_clk_i);
    req_valid_o <= 1'b0;
    req_crm_o   <= ~crm;
    req_op2_o   <= ~op2;
    req_wdata_o <= ~wd;
  endtask
endmodule

// File: dv/vbp_regs_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module vbp_regs_tb;
  localparam logic [3:0] B0 = vbp_pkg::ENC_CRM_BP0;
  localparam logic [3:0] B1 = vbp_pkg::ENC_CRM_BP1;
  localparam logic [3:0] AP = vbp_pkg::ENC_CRM_AP1;
  localparam logic [6:0] NORM = 7'b1111000;
  int failures = 0, check_count = 0, cycles = 0;
  logic core_clk_i, reset_n_i = 1'b0, req_ns_el1_i = 1'b0;
  logic virtual_irq_routing_bit_i = 1'b0, virtual_fiq_routing_bit_i = 1'b0;
  logic el1_sysreg_enable_bit_i = 1'b0, trap_all_group0_bit_i = 1'b0;
  logic trap_all_group1_bit_i = 1'b0, common_binary_point_bit_i = 1'b0;
  logic [2:0] priority_bit_count_i = 3'h4, req_op1_i, req_op2_i;
  logic [1:0] req_op0_i;
  logic [3:0] req_crn_i, req_crm_i;
  logic [31:0] req_wdata_i, rsp_rdata_o;
  logic req_valid_i, req_write_i, rsp_valid_o, rsp_phys_o, rsp_trap_el1_o;
  logic rsp_trap_el2_o, rsp_unmapped_o, group1_any_active_o;
  logic [2:0] group0_binary_point_o, group1_binary_point_o;
  logic [7:0] group0_preempt_mask_o, group1_preempt_mask_o;

  vbp_core_model core (.core_clk_i(core_clk_i), .req_valid_o(req_valid_i),
    .req_write_o(req_write_i), .req_op0_o(req_op0_i), .req_op1_o(req_op1_i),
    .req_crn_o(req_crn_i), .req_crm_o(req_crm_i), .req_op2_o(req_op2_i),
    .req_wdata_o(req_wdata_i));
  vbp_regs dut (.*);

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] pc);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    priority_bit_count_i <= pc;
    repeat (4) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
  endtask
  task automatic ctl(input logic [6:0] v);
    @(posedge core_clk_i);
    {req_ns_el1_i, virtual_irq_routing_bit_i, virtual_fiq_routing_bit_i,
     el1_sysreg_enable_bit_i, trap_all_group0_bit_i, trap_all_group1_bit_i,
     common_binary_point_bit_i} <= v;
  endtask
  task automatic rd(input logic [3:0] crm, input logic [2:0] op2,
                    input logic [31:0] exp);
    core.access(1'b0, crm, op2, 32'h0);
    #1;
    `CHK(rsp_valid_o, 1'b1)
    `CHK(rsp_rdata_o, exp)
  endtask
  task automatic wr(input logic [3:0] crm, input logic [2:0] op2,
                    input logic [31:0] wd);
    core.access(1'b1, crm, op2, wd);
    #1;
    `CHK(rsp_valid_o, 1'b1)
  endtask
  task automatic refuse(input logic [3:0] crm, input logic [3:0] exp);
    core.access(1'b1, crm, 3'h3, 32'h0);
    #1;
    `CHK({rsp_phys_o, rsp_trap_el1_o, rsp_trap_el2_o, rsp_unmapped_o}, exp)
  endtask

  task automatic t_reset_vals(input logic [2:0] pc);
    logic [2:0] m;
    m = (pc == 3'h7) ? 3'h0 : 3'h6 - pc;
    rd(B0, 3'h3, {29'h0, m});
    rd(B1, 3'h3, {29'h0, m + 3'h1});
    for (int n = 0; n < 4; n++) rd(AP, 3'(n), 32'h0);
    `CHK(group1_any_active_o, 1'b0)
  endtask
  task automatic t_bp0;
    wr(B0, 3'h3, 32'h0);
    rd(B0, 3'h3, 32'h2);
    wr(B0, 3'h3, 32'hffff_fff5);
    rd(B0, 3'h3, 32'h5);
    `CHK(group0_preempt_mask_o, 8'hc0)
    wr(B0, 3'h3, 32'h7);
    rd(B0, 3'h3, 32'h7);
    `CHK(group0_preempt_mask_o, 8'h00)
  endtask
  task automatic t_bp1;
    wr(B1, 3'h3, 32'h0);
    rd(B1, 3'h3, 32'h3);
    wr(B1, 3'h3, 32'h2);
    rd(B1, 3'h3, 32'h3);
    wr(B1, 3'h3, 32'h6);
    rd(B1, 3'h3, 32'h6);
    `CHK(group1_preempt_mask_o, 8'hc0)
    ctl(7'b1111001);
    rd(B1, 3'h3, 32'h7);
    wr(B1, 3'h3, 32'h4);
    `CHK(group1_binary_point_o, 3'h6)
    ctl(NORM);
  endtask
  task automatic t_ap1;
    for (int n = 0; n < 4; n++) wr(AP, 3'(n), 32'h1 << (n * 8));
    `CHK(group1_any_active_o, 1'b1)
    for (int n = 0; n < 4; n++) rd(AP, 3'(n), 32'h1 << (n * 8));
    for (int n = 0; n < 4; n++) wr(AP, 3'(n), 32'h0);
    `CHK(group1_any_active_o, 1'b0)
  endtask
  task automatic t_route;
    ctl(7'b1011000);
    refuse(B1, 4'b1000);
    ctl(7'b1101000);
    refuse(B0, 4'b1000);
    ctl(7'b0111000);
    refuse(B0, 4'b1000);
    ctl(7'b1110000);
    refuse(B1, 4'b0100);
    ctl(7'b1111100);
    refuse(B0, 4'b0010);
    ctl(7'b1111010);
    refuse(B1, 4'b0010);
    refuse(4'h0, 4'b0001);
    ctl(NORM);
    rd(B0, 3'h3, 32'h7);
    rd(B1, 3'h3, 32'h6);
  endtask

  initial begin
    do_reset(3'h4);
    ctl(NORM);
    t_reset_vals(3'h4);
    t_bp0();
    t_bp1();
    t_ap1();
    t_route();
    do_reset(3'h7);
    t_reset_vals(3'h7);
    report_and_stop();
  end
endmodule
